// *** hbh_cnt.sv ***
// Saturating up-counter with synchronous clear
`timescale 1ns/1ps
module hbh_cnt import hbh_pkg::*; #(
  parameter int W = CNT_W
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Control
  input wire logic clr_in,
  input wire logic inc_in,
  output logic [W-1:0] count_out
);
  typedef struct packed {
    logic [W-1:0] c;
  } hbh_cnt_st_t;

  hbh_cnt_st_t st_q;
  hbh_cnt_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (clr_in) begin
      st_d.c = '0;
    end else if (inc_in && (st_q.c != {W{1'b1}})) begin
      st_d.c = st_q.c + W'(1);
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count_out = st_q.c;
endmodule // hbh_cnt

// *** hbh_hold.sv ***
// Bus hold handshake: hands the external memory port to an outside master
// Notes on behaviour
// R1 - Hold request synchronised; may arrive asynchronously
// R2 - Pending memory transactions finish before grant
// R3 - Float bus no sooner than 4 periods
// R4 - Grant goes low within 2 periods of float
// R5 - Grant returns high 4 to 7 periods
// R6 - Bus redriven 3 to 6 periods after release
// R7 - Hold disable bit blocks the grant entirely
// R8 - Burst priority: finish eight SDRAM accesses first
// R9 - Idle bus grants at the least delay
// R10 - Whole memory bus group floats and redrives
// R11 - Outside master drives only while granted
`timescale 1ns/1ps
module hbh_hold import hbh_pkg::*; (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Hold handshake pins
  input wire logic bus_hold_req_n_in,
  output logic bus_hold_grant_n_out,
  // Configuration
  input wire logic hold_disable_bit_in,
  input wire logic sdram_burst_priority_bit_in,
  // Memory controller side
  input wire logic mc_busy_in,
  input wire logic mc_sdram_xfer_in,
  output logic mc_hold_stall_out,
  input wire logic [3:0] mc_ce_n_in,
  input wire logic [3:0] mc_be_n_in,
  input wire logic [31:0] mc_data_in,
  input wire logic mc_data_oe_in,
  input wire logic [21:2] mc_addr_in,
  input wire logic mc_async_read_enable_in,
  input wire logic mc_async_output_enable_in,
  input wire logic mc_async_write_strobe_in,
  input wire logic mc_burst_sram_address_strobe_in,
  input wire logic mc_burst_sram_output_enable_in,
  input wire logic mc_burst_sram_write_enable_in,
  input wire logic mc_sdram_address_bit_ten_in,
  input wire logic mc_sdram_row_strobe_in,
  input wire logic mc_sdram_column_strobe_in,
  input wire logic mc_sdram_write_enable_in,
  // External memory port pins
  output logic memory_port_oe_out,
  output logic [3:0] chip_enable_n_out,
  output logic [3:0] byte_enable_lines_out,
  output logic [31:0] memory_data_lines_out,
  output logic memory_data_lines_oe_out,
  output logic [21:2] memory_address_lines_out,
  output logic async_read_enable_out,
  output logic async_output_enable_out,
  output logic async_write_strobe_out,
  output logic burst_sram_address_strobe_out,
  output logic burst_sram_output_enable_out,
  output logic burst_sram_write_enable_out,
  output logic sdram_address_bit_ten_out,
  output logic sdram_row_strobe_out,
  output logic sdram_column_strobe_out,
  output logic sdram_write_enable_out
);
  typedef struct packed {
    hbh_state_t st;
    logic grant_n;
    logic oe;
    logic ed_oe;
    logic [3:0] ce;
    logic [3:0] be;
    logic [31:0] ed;
    logic [21:2] ea;
    logic [9:0] strb;
  } hbh_hold_st_t;

  hbh_hold_st_t q;
  hbh_hold_st_t d;

  logic req_n_sync;
  logic req_act;
  logic [CNT_W-1:0] ph_cnt;
  logic [CNT_W-1:0] run_cnt;
  logic ph_clr;
  logic ph_inc;
  logic run_clr;
  logic burst_hold;

  // Metastability guard on the pin [R1]
  hbh_sync #(
    .RST_VAL(REQ_N_RST)
  ) u_req_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .async_in(bus_hold_req_n_in),
    .sync_out(req_n_sync)
  );

  assign req_act = !req_n_sync;

  // Phase counter restarts whenever a timed state is entered
  assign ph_clr = (q.st == ST_OWN) || (q.st == ST_GRANT) || (q.st == ST_FLOAT);
  assign ph_inc = (q.st == ST_WAIT) || (q.st == ST_REL);

  hbh_cnt #(
    .W(CNT_W)
  ) u_ph_cnt (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .clr_in(ph_clr),
    .inc_in(ph_inc),
    .count_out(ph_cnt)
  );

  // Consecutive SDRAM accesses; a gap in ST_OWN ends the run.
  // The run under way as the request arrives counts, so it is not cut short.
  assign run_clr = (q.st == ST_OWN) && !mc_sdram_xfer_in;

  hbh_cnt #(
    .W(CNT_W)
  ) u_run_cnt (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .clr_in(run_clr),
    .inc_in(mc_sdram_xfer_in),
    .count_out(run_cnt)
  );

  // A started SDRAM run keeps the bus until it reaches the least length [R8]
  assign burst_hold = sdram_burst_priority_bit_in && (run_cnt != '0) && (run_cnt < BURST_MIN);

  always_comb begin
    d = q;
    // Pin values follow the controller; the enable alone decides who drives [R10]
    d.ce = mc_ce_n_in;
    d.be = mc_be_n_in;
    d.ed = mc_data_in;
    d.ea = mc_addr_in;
    d.strb = {mc_async_read_enable_in, mc_async_output_enable_in, mc_async_write_strobe_in,
              mc_burst_sram_address_strobe_in, mc_burst_sram_output_enable_in,
              mc_burst_sram_write_enable_in, mc_sdram_address_bit_ten_in,
              mc_sdram_row_strobe_in, mc_sdram_column_strobe_in, mc_sdram_write_enable_in};
    case (q.st)
      ST_OWN: begin
        if (req_act && !hold_disable_bit_in) begin // [R7]
          d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!req_act || hold_disable_bit_in) begin // [R7]
          d.st = ST_OWN;
        end else if ((ph_cnt >= WAIT_CNT) && !mc_busy_in && !mc_sdram_xfer_in && !burst_hold) begin // [R2] [R3] [R9]
          d.st = ST_FLOAT;
          d.oe = 1'b0;
        end
      end
      ST_FLOAT: begin
        // Grant follows the float by one edge [R4]
        d.grant_n = 1'b0;
        d.st = ST_GRANT;
      end
      ST_GRANT: begin
        if (!req_act) begin
          d.st = ST_REL;
        end
      end
      ST_REL: begin
        if (ph_cnt == REL_DRV_CNT) begin // [R6]
          d.oe = 1'b1;
        end
        if (ph_cnt == REL_GNT_CNT) begin // [R5]
          d.grant_n = 1'b1;
          d.st = ST_OWN;
        end
      end
      default: begin
        d.st = ST_OWN;
        d.grant_n = GRANT_N_RST;
        d.oe = PORT_OE_RST;
      end
    endcase
    // Data lines never drive while the port is floated [R10]
    d.ed_oe = d.oe && mc_data_oe_in;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.st <= ST_OWN;
      q.grant_n <= GRANT_N_RST;
      q.oe <= PORT_OE_RST;
    end else begin
      q <= d;
    end
  end

  // Controller must not start new cycles once the hold is under way, save a started SDRAM run still short of BURST_MIN [R2] [R8]
  assign mc_hold_stall_out = ((q.st == ST_WAIT) && !burst_hold) || (q.st == ST_FLOAT) ||
                             (q.st == ST_GRANT) || (q.st == ST_REL);

  assign bus_hold_grant_n_out = q.grant_n;
  assign memory_port_oe_out = q.oe;
  assign memory_data_lines_oe_out = q.ed_oe;
  assign chip_enable_n_out = q.ce;
  assign byte_enable_lines_out = q.be;
  assign memory_data_lines_out = q.ed;
  assign memory_address_lines_out = q.ea;
  assign async_read_enable_out = q.strb[9];
  assign async_output_enable_out = q.strb[8];
  assign async_write_strobe_out = q.strb[7];
  assign burst_sram_address_strobe_out = q.strb[6];
  assign burst_sram_output_enable_out = q.strb[5];
  assign burst_sram_write_enable_out = q.strb[4];
  assign sdram_address_bit_ten_out = q.strb[3];
  assign sdram_row_strobe_out = q.strb[2];
  assign sdram_column_strobe_out = q.strb[1];
  assign sdram_write_enable_out = q.strb[0];

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);

  // Synchronised request lags the pin by exactly two edges
  property p_sync_lag;
    req_n_sync == $past(bus_hold_req_n_in, 2);
  endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("hold request sync lag wrong"); // [R1]

  // The port only floats once the controller is idle
  property p_idle_before_float;
    $fell(memory_port_oe_out) |-> $past(!mc_busy_in) && $past(!mc_sdram_xfer_in);
  endproperty
  a_idle_before_float: assert property (p_idle_before_float) else $error("float while busy"); // [R2]

  // Request seen for at least three cycles before the float edge
  property p_float_min;
    $fell(memory_port_oe_out) |-> $past(req_act) && $past(req_act, 2) && $past(req_act, 3);
  endproperty
  a_float_min: assert property (p_float_min) else $error("float too early"); // [R3]

  sequence s_float;
    $fell(memory_port_oe_out);
  endsequence

  property p_grant_after_float;
    s_float |-> ##[1:2] !bus_hold_grant_n_out;
  endproperty
  a_grant_after_float: assert property (p_grant_after_float) else $error("grant late"); // [R4]

  sequence s_release_granted;
    $rose(req_n_sync) && !bus_hold_grant_n_out;
  endsequence

  property p_grant_release;
    s_release_granted |-> !bus_hold_grant_n_out ##1 !bus_hold_grant_n_out ##[1:3] bus_hold_grant_n_out;
  endproperty
  a_grant_release: assert property (p_grant_release) else $error("grant release out of window"); // [R5]

  property p_redrive;
    s_release_granted |-> !memory_port_oe_out ##[1:4] memory_port_oe_out;
  endproperty
  a_redrive: assert property (p_redrive) else $error("bus redrive out of window"); // [R6]

  property p_disable_blocks;
    hold_disable_bit_in && bus_hold_grant_n_out && memory_port_oe_out |=> memory_port_oe_out;
  endproperty
  a_disable_blocks: assert property (p_disable_blocks) else $error("grant while disabled"); // [R7]

  property p_burst_first;
    $fell(memory_port_oe_out) && sdram_burst_priority_bit_in |-> ($past(run_cnt) == '0) || ($past(run_cnt) >= BURST_MIN);
  endproperty
  a_burst_first: assert property (p_burst_first) else $error("burst cut short"); // [R8]

  sequence s_idle_request;
    $rose(req_act) && (q.st == ST_OWN) ##1
      (!mc_busy_in && !mc_sdram_xfer_in && !hold_disable_bit_in && req_act && (run_cnt == '0))[*2];
  endsequence

  property p_idle_fast;
    s_idle_request |=> !memory_port_oe_out;
  endproperty
  a_idle_fast: assert property (p_idle_fast) else $error("idle grant not at least delay"); // [R9]

  property p_group_float;
    (!memory_port_oe_out |-> !memory_data_lines_oe_out) and (!bus_hold_grant_n_out && req_act |-> !memory_port_oe_out);
  endproperty
  a_group_float: assert property (p_group_float) else $error("bus driven during hold"); // [R10]

  // Once floated, the port stays off while the request is still seen
  property p_float_hold;
    !memory_port_oe_out && req_act |=> !memory_port_oe_out;
  endproperty
  a_float_hold: assert property (p_float_hold) else $error("port redriven during hold"); // [R10]

  // Grant only ever falls on a port that is already floated
  property p_grant_on_float;
    $fell(bus_hold_grant_n_out) |-> $past(!memory_port_oe_out);
  endproperty
  a_grant_on_float: assert property (p_grant_on_float) else $error("grant before float"); // [R4]

  // Controller is held off for as long as the port is lent out
  property p_stall_in_hold;
    !bus_hold_grant_n_out |-> mc_hold_stall_out;
  endproperty
  a_stall_in_hold: assert property (p_stall_in_hold) else $error("controller free during hold"); // [R2]

  // Controller gets the port back once the grant is handed back
  property p_stall_release;
    s_release_granted |-> ##3 !mc_hold_stall_out;
  endproperty
  a_stall_release: assert property (p_stall_release) else $error("controller still stalled"); // [R6]
endmodule // hbh_hold

// *** hbh_master.sv ***
// Outside bus master that borrows the memory port
`timescale 1ns/1ps
module hbh_master (
  // Clock and handshake
  input wire logic clock_in,
  input wire logic bus_hold_grant_n_in,
  output logic bus_hold_req_n_out,
  // Bench control
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [7:0] hold_len_in,
  input wire logic [4:0] skew_in,
  output logic bus_oe_out
);
  initial begin
    bus_hold_req_n_out = 1'b1;
    bus_oe_out = 1'b0;
    forever begin
      @(posedge start_in);
      @(negedge clock_in);
      // Off-grid edge so the request is truly asynchronous
      #(skew_in) bus_hold_req_n_out = 1'b0;
      while (bus_hold_grant_n_in !== 1'b0 && !abort_in) @(posedge clock_in);
      if (!abort_in) begin
        @(posedge clock_in);
        bus_oe_out = 1'b1;
        repeat (hold_len_in) @(posedge clock_in);
        bus_oe_out = 1'b0;
        @(posedge clock_in);
      end
      @(negedge clock_in);
      #(skew_in) bus_hold_req_n_out = 1'b1;
    end
  end
endmodule // hbh_master

// *** hbh_pkg.sv ***
// Shared constants and types for the external bus hold handshake
package hbh_pkg;
  // One CPU clock period, and the period of clock_in
  localparam int CPU_P_NS = 50;
  localparam int CLK_NS = 50;
  // Depth of the request synchroniser
  localparam int SYNC_CYC = 2;
  // Response times in CPU periods
  localparam int HZ_MIN_P = 4;
  localparam int GNT_MAX_P = 2;
  localparam int GNT_REL_MIN_P = 4;
  localparam int GNT_REL_MAX_P = 7;
  localparam int DRV_MIN_P = 3;
  localparam int DRV_MAX_P = 6;
  // Least times round up, longest times round down
  localparam int HZ_MIN_CYC = (HZ_MIN_P * CPU_P_NS + CLK_NS - 1) / CLK_NS;
  localparam int GNT_MAX_CYC = (GNT_MAX_P * CPU_P_NS) / CLK_NS;
  localparam int GNT_REL_MIN_CYC = (GNT_REL_MIN_P * CPU_P_NS + CLK_NS - 1) / CLK_NS;
  localparam int GNT_REL_MAX_CYC = (GNT_REL_MAX_P * CPU_P_NS) / CLK_NS;
  localparam int DRV_MIN_CYC = (DRV_MIN_P * CPU_P_NS + CLK_NS - 1) / CLK_NS;
  localparam int DRV_MAX_CYC = (DRV_MAX_P * CPU_P_NS) / CLK_NS;
  // Phase counter targets, measured after the synchroniser and the state step
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] WAIT_CNT = CNT_W'(HZ_MIN_CYC - SYNC_CYC - 1);
  localparam logic [CNT_W-1:0] REL_DRV_CNT = CNT_W'(DRV_MIN_CYC - SYNC_CYC - 1);
  localparam logic [CNT_W-1:0] REL_GNT_CNT = CNT_W'(GNT_REL_MIN_CYC - SYNC_CYC - 1);
  // Least SDRAM run before a hold while burst priority is set
  localparam logic [CNT_W-1:0] BURST_MIN = 4'h8;
  // Reset values
  localparam logic REQ_N_RST = 1'b1;
  localparam logic GRANT_N_RST = 1'b1;
  localparam logic PORT_OE_RST = 1'b1;
  typedef enum logic [4:0] {
    ST_OWN = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_FLOAT = 5'b00100,
    ST_GRANT = 5'b01000,
    ST_REL = 5'b10000
  } hbh_state_t;
endpackage

// *** hbh_sync.sv ***
// Two-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
module hbh_sync import hbh_pkg::*; #(
  parameter logic RST_VAL = REQ_N_RST
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Level
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } hbh_sync_st_t;

  hbh_sync_st_t st_q;
  hbh_sync_st_t st_d;

  always_comb begin
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;
endmodule // hbh_sync

// *** tb.sv ***
// Self-checking bench for the bus hold handshake
`timescale 1ns/1ps
module tb;
  import hbh_pkg::*;
  logic clock_in, rst_b_in, req_n, grant_n, dis, prio, busy, xfer, stall;
  logic start, abort, m_oe, port_oe, d_oe, doe_in, doe_prev, run_mon;
  logic [7:0] len;
  logic [4:0] skew;
  logic [3:0] ce, be, ce_o, be_o;
  logic [31:0] dat, dat_o;
  logic [21:2] adr, adr_o;
  logic [9:0] stb, stb_o;
  logic [69:0] prev;
  time t_req, t_rel, t_fl, t_drv, t_gr, t_ug, t_bf;
  int n_tests, n_mismatch, n_xfer, i;

  hbh_hold DUT (.clock_in(clock_in), .rst_b_in(rst_b_in), .bus_hold_req_n_in(req_n),
    .bus_hold_grant_n_out(grant_n), .hold_disable_bit_in(dis), .sdram_burst_priority_bit_in(prio),
    .mc_busy_in(busy), .mc_sdram_xfer_in(xfer), .mc_hold_stall_out(stall), .mc_ce_n_in(ce),
    .mc_be_n_in(be), .mc_data_in(dat), .mc_data_oe_in(doe_in), .mc_addr_in(adr),
    .mc_async_read_enable_in(stb[9]), .mc_async_output_enable_in(stb[8]),
    .mc_async_write_strobe_in(stb[7]), .mc_burst_sram_address_strobe_in(stb[6]),
    .mc_burst_sram_output_enable_in(stb[5]), .mc_burst_sram_write_enable_in(stb[4]),
    .mc_sdram_address_bit_ten_in(stb[3]), .mc_sdram_row_strobe_in(stb[2]),
    .mc_sdram_column_strobe_in(stb[1]), .mc_sdram_write_enable_in(stb[0]),
    .memory_port_oe_out(port_oe), .chip_enable_n_out(ce_o), .byte_enable_lines_out(be_o),
    .memory_data_lines_out(dat_o), .memory_data_lines_oe_out(d_oe), .memory_address_lines_out(adr_o),
    .async_read_enable_out(stb_o[9]), .async_output_enable_out(stb_o[8]),
    .async_write_strobe_out(stb_o[7]), .burst_sram_address_strobe_out(stb_o[6]),
    .burst_sram_output_enable_out(stb_o[5]), .burst_sram_write_enable_out(stb_o[4]),
    .sdram_address_bit_ten_out(stb_o[3]), .sdram_row_strobe_out(stb_o[2]),
    .sdram_column_strobe_out(stb_o[1]), .sdram_write_enable_out(stb_o[0]));

  hbh_master PEER (.clock_in(clock_in), .bus_hold_grant_n_in(grant_n), .bus_hold_req_n_out(req_n),
    .start_in(start), .abort_in(abort), .hold_len_in(len), .skew_in(skew), .bus_oe_out(m_oe));

  task automatic chk(input logic [69:0] got, input logic [69:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(negedge req_n) t_req = $time;
  always @(posedge req_n) t_rel = $time;
  always @(negedge port_oe) t_fl = $time;
  always @(posedge port_oe) t_drv = $time;
  always @(negedge grant_n) t_gr = $time;
  always @(posedge grant_n) t_ug = $time;

  // Controller side: fresh pin values every cycle, copies checked a cycle on
  always @(negedge clock_in) begin
    if (run_mon) begin
      chk({ce_o, be_o, adr_o, stb_o, dat_o}, prev);
      chk(d_oe, port_oe & doe_prev);
      chk(m_oe & port_oe, 1'b0);
    end
    {ce, be, adr, stb} = 38'({$urandom, $urandom});
    dat = $urandom;
    doe_in = 1'($urandom);
    doe_prev = doe_in;
    prev = {ce, be, adr, stb, dat};
    // Keep an SDRAM run going while the stall allows it
    xfer = prio && req_n === 1'b0 && stall === 1'b0 && grant_n === 1'b1;
    if (xfer) n_xfer++;
  end

  task automatic hold_test(input int nbusy, input logic p, input logic d);
    int k;
    dis = d;
    prio = p;
    n_xfer = 0;
    t_fl = 0;
    t_gr = 0;
    t_ug = 0;
    len = 8'($urandom_range(1, 6));
    skew = 5'($urandom_range(1, 20));
    start = 1'b1;
    @(negedge clock_in);
    start = 1'b0;
    busy = (nbusy > 0);
    repeat (nbusy) @(negedge clock_in);
    busy = 1'b0;
    t_bf = $time;
    if (d) begin
      repeat (40) @(negedge clock_in);
      chk({t_fl == 0, t_gr == 0, port_oe, grant_n}, 4'hF);
      abort = 1'b1;
      for (k = 0; k < 20 && req_n !== 1'b1; k++) @(negedge clock_in);
      abort = 1'b0;
    end else begin
      for (k = 0; k < 300 && t_ug == 0; k++) @(negedge clock_in);
      repeat (2) @(negedge clock_in);
      chk(t_fl - t_req >= 4 * CPU_P_NS, 1'b1);
      chk(t_gr > t_fl && t_gr - t_fl <= 2 * CPU_P_NS, 1'b1);
      chk(t_fl > t_bf, 1'b1);
      chk(t_ug - t_rel >= 4 * CPU_P_NS && t_ug - t_rel <= 7 * CPU_P_NS, 1'b1);
      chk(t_drv - t_rel >= 3 * CPU_P_NS && t_drv - t_rel <= 6 * CPU_P_NS, 1'b1);
      if (p) chk(n_xfer >= 8, 1'b1);
      // Idle bus: least delay, one extra period if the synchroniser misses
      if (nbusy == 0 && !p) chk(t_fl - t_req <= (HZ_MIN_P + 1) * CPU_P_NS, 1'b1);
    end
    $display("hold test busy=%0d prio=%0b dis=%0b done", nbusy, p, d);
  endtask

  initial begin
    clock_in = 1'b0;
    forever #(CLK_NS / 2) clock_in = ~clock_in;
  end

  initial begin
    #(4000 * CLK_NS);
    n_mismatch++;
    complete_run();
  end

  initial begin
    {rst_b_in, dis, prio, busy, xfer, start, abort, run_mon, doe_in} = '0;
    {ce, be, adr, stb, dat} = '0;
    n_tests = 0;
    n_mismatch = 0;
    n_xfer = 0;
    void'($urandom(32'h81EF7DC9));
    repeat (4) @(negedge clock_in);
    chk({grant_n, port_oe, d_oe, stall}, 4'hC);
    rst_b_in = 1'b1;
    @(negedge clock_in);
    chk({grant_n, port_oe, stall}, 3'h6);
    run_mon = 1'b1;
    hold_test(0, 1'b0, 1'b0);
    hold_test(5, 1'b0, 1'b0);
    hold_test(0, 1'b1, 1'b0);
    hold_test(0, 1'b0, 1'b1);
    for (i = 0; i < 6; i++) hold_test($urandom_range(0, 7), 1'($urandom_range(0, 1)), 1'b0);
    complete_run();
  end
endmodule // tb
